// ==== verilog/iobso_exec.sv ====
// Decode and execute of the indexed bit-set and fill-ones forms, with its data memory.
// Assumes instr is presented and held by the fetch logic for a whole instruction cycle
// starting at the clock when instr_valid is high in Q1.
//
// Functional notes
// - With extended mode on, upper nibble 1000, bit number, zero flag, offset byte.
// - Bit-set indexed sets chosen bit at frame pointer plus offset, nothing else.
// - Fill-ones indexed recognised from opcode byte 0110 1000, offset 0 to 95.
// - Fill-ones indexed writes FFh at frame pointer plus offset, flags unchanged.
// - Extended-mode enable defaults to zero; then forms keep standard meaning.
// - Indexed only if access flag zero and argument at most 5Fh.
// - Frame pointer 00h makes indexed accesses hit original access bank locations.
`timescale 1ns/100ps
module iobso_exec
    import iobso_pkg::*;
#(
    parameter int MEM_DEPTH = 4096
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic extended_set_enable,
    input wire logic [IW_W-1:0] instr,
    input wire logic instr_valid,
    input wire logic [ADDR_W-1:0] stack_frame_pointer,
    output logic [1:0] phase,
    output logic indexed_hit,
    output logic done,
    output logic [ADDR_W-1:0] last_addr,
    output logic [DATA_W-1:0] last_wdata
);
    iobso_dmem_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) dmem ();

    iobso_phase_t phase_r;
    iobso_op_t op_r;
    logic ext_en_r;
    logic busy_r;
    logic [2:0] bit_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic we_r;
    logic hit_r;
    logic done_r;
    logic [ADDR_W-1:0] last_addr_r;
    logic [DATA_W-1:0] last_wdata_r;
    iobso_op_t op_nxt;
    wire logic [DATA_W-1:0] set_byte;

    // ==========================================================
    // Decode
    // Offset byte of a word; the same field feeds the range test and the adder
    function automatic logic [7:0] arg_of(input logic [IW_W-1:0] iw);
        return iw[7:0];
    endfunction : arg_of

    // True for a decoded word that must end in a memory write
    function automatic logic is_exec(input iobso_op_t op);
        return op != IOBSO_OP_NONE;
    endfunction : is_exec

    // Indexed forms need the enable, a clear access flag and a small argument
    function automatic iobso_op_t decode_op(input logic [IW_W-1:0] iw, input logic en);
        iobso_op_t op;
        logic small_arg;
        op = IOBSO_OP_NONE;
        small_arg = (arg_of(iw) <= OFFSET_MAX);
        if (en && small_arg) begin
            if (iw[IW_W-1:OPC_HI_POS] == OPC_BIT_SET && !iw[ACCESS_FLAG_POS]) begin
                op = IOBSO_OP_BIT_SET;
            end else if (iw[IW_W-1:8] == OPC_FILL_ONES) begin
                op = IOBSO_OP_FILL;
            end
        end
        return op;
    endfunction : decode_op

    assign op_nxt = decode_op(instr, ext_en_r);

    // ==========================================================
    // Enable capture
    // Enable is caught after reset release, held low while in reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_en_r <= 1'b0;
        end else begin
            ext_en_r <= extended_set_enable;
        end
    end

    // ==========================================================
    // Phase sequencing
    // Phases run freely so every instruction cycle is exactly four clocks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_r <= IOBSO_Q1;
        end else begin
            case (phase_r)
                IOBSO_Q1: phase_r <= IOBSO_Q2;
                IOBSO_Q2: phase_r <= IOBSO_Q3;
                IOBSO_Q3: phase_r <= IOBSO_Q4;
                IOBSO_Q4: phase_r <= IOBSO_Q1;
                default: phase_r <= IOBSO_Q1;
            endcase
        end
    end

    // ==========================================================
    // Q1 capture
    // Operation kind; a word not marked valid decodes to nothing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_r <= IOBSO_OP_NONE;
        end else if (phase_r == IOBSO_Q1) begin
            op_r <= instr_valid ? op_nxt : IOBSO_OP_NONE;
        end
    end

    // Busy marks an instruction cycle that ends in a write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_r <= 1'b0;
        end else if (phase_r == IOBSO_Q1) begin
            busy_r <= instr_valid && is_exec(op_nxt);
        end
    end

    // Bit number is taken for every word; only the bit-set form uses it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_r <= 3'h0;
        end else if (phase_r == IOBSO_Q1) begin
            bit_r <= instr[BIT_NUM_POS +: 3];
        end
    end

    // Address adder wraps at the top of data space; no carry is kept
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_r <= FRAME_PTR_RST;
        end else if (phase_r == IOBSO_Q1) begin
            // Zero pointer leaves the address equal to the offset itself
            addr_r <= stack_frame_pointer + ADDR_W'(arg_of(instr));
        end
    end

    // ==========================================================
    // Operand merge
    // One lane per bit: a lane is forced high only when it is the selected bit
    for (genvar i = 0; i < DATA_W; i++) begin : g_lane
        assign set_byte[i] = dmem.rdata[i] | (bit_r == 3'(i));
    end

    // ==========================================================
    // Process and write
    // Strobe high through Q4 only, so the memory writes at the Q4 edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            we_r <= 1'b0;
        end else begin
            we_r <= (phase_r == IOBSO_Q3) && busy_r;
        end
    end

    // Q2 read data is stable by Q3, where the byte to write is formed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdata_r <= BYTE_RST;
        end else if (phase_r == IOBSO_Q3 && busy_r) begin
            case (op_r)
                IOBSO_OP_BIT_SET: wdata_r <= set_byte;
                IOBSO_OP_FILL: wdata_r <= FILL_VALUE;
                default: wdata_r <= dmem.rdata;
            endcase
        end
    end

    // ==========================================================
    // Memory port
    // Address, strobe and data all come from registers, so the port is glitch free
    assign dmem.addr = addr_r;
    assign dmem.we = we_r;
    assign dmem.wdata = wdata_r;

    iobso_dmem #(.DEPTH(MEM_DEPTH)) u_mem (
        .clk(clk),
        .port(dmem.mem)
    );

    // ==========================================================
    // Observation outputs
    // Hit stands from its Q1 edge to the next one, whatever the word was
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hit_r <= 1'b0;
        end else if (phase_r == IOBSO_Q1) begin
            hit_r <= instr_valid && is_exec(op_nxt);
        end
    end

    // Done trails the write strobe by one clock and lasts one clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_r <= 1'b0;
        end else begin
            done_r <= we_r;
        end
    end

    // No status flags exist here; only the written byte and address are reported
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_addr_r <= FRAME_PTR_RST;
            last_wdata_r <= BYTE_RST;
        end else if (we_r) begin
            last_addr_r <= addr_r;
            last_wdata_r <= wdata_r;
        end
    end

    assign phase = phase_r;
    assign indexed_hit = hit_r;
    assign done = done_r;
    assign last_addr = last_addr_r;
    assign last_wdata = last_wdata_r;
endmodule : iobso_exec

// ==== verilog/iobso_pkg.sv ====
// Package for the indexed offset bit-set / fill-ones execute block.
// Assumes a 16-bit program word, 8-bit data and a 12-bit data address space.
package iobso_pkg;
    // ==========================================================
    // Encoding fields
    localparam int IW_W = 16;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;
    localparam logic [3:0] OPC_BIT_SET = 4'h8;          // Upper nibble 1000
    localparam logic [7:0] OPC_FILL_ONES = 8'h68;       // 0110 1000
    localparam int OPC_HI_POS = 12;
    localparam int BIT_NUM_POS = 9;
    localparam int ACCESS_FLAG_POS = 8;                 // Bit following bit number
    localparam logic [7:0] OFFSET_MAX = 8'h5F;          // Largest indexed argument, 95
    localparam logic [7:0] FILL_VALUE = 8'hFF;
    localparam logic [11:0] FRAME_PTR_RST = 12'h000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // ==========================================================
    // Instruction cycle phases
    typedef enum logic [1:0] {
        IOBSO_Q1,
        IOBSO_Q2,
        IOBSO_Q3,
        IOBSO_Q4
    } iobso_phase_t;
    typedef enum logic [1:0] {
        IOBSO_OP_NONE,
        IOBSO_OP_BIT_SET,
        IOBSO_OP_FILL
    } iobso_op_t;
endpackage : iobso_pkg

// ==== verilog/iobso_dmem_if.sv ====
// Interface carrying the data memory read and write port between core and memory.
// Assumes one clock; read data arrives registered one clock after the address.
`timescale 1ns/100ps
interface iobso_dmem_if #(parameter int ADDR_W = 12, parameter int DATA_W = 8);
    logic [ADDR_W-1:0] addr;
    logic we;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    modport core (output addr, output we, output wdata, input rdata);
    modport mem (input addr, input we, input wdata, output rdata);
endinterface : iobso_dmem_if

// ==== verilog/iobso_dmem.sv ====
// Small data memory, one read/write port, registered read data.
// Assumes a single clock; contents are not reset.
`timescale 1ns/100ps
module iobso_dmem #(
    parameter int DEPTH = 4096
) (
    input wire logic clk,
    iobso_dmem_if.mem port
);
    logic [7:0] mem_r [DEPTH];
    logic [7:0] rdata_r;

    // ==========================================================
    // Storage
    // Write on enable; read data registered so the core sees it next clock
    always_ff @(posedge clk) begin
        if (port.we) begin
            mem_r[port.addr] <= port.wdata;
        end
        rdata_r <= mem_r[port.addr];
    end
    assign port.rdata = rdata_r;
endmodule : iobso_dmem

// ==== tb/iobso_chk.sv ====
// Checker for the indexed bit-set and fill-ones execute block.
// Assumes it is bound to iobso_exec and sees only its ports.
`timescale 1ns/100ps
module iobso_chk
    import iobso_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic extended_set_enable,
    input wire logic [IW_W-1:0] instr,
    input wire logic instr_valid,
    input wire logic [ADDR_W-1:0] stack_frame_pointer,
    input wire logic [1:0] phase,
    input wire logic indexed_hit,
    input wire logic done,
    input wire logic [ADDR_W-1:0] last_addr,
    input wire logic [DATA_W-1:0] last_wdata
);
    // ==========================================================
    // Helpers: a word that may be indexed, and its byte address
    logic go;
    logic [ADDR_W-1:0] ea;
    assign go = phase == 2'd0 && instr_valid && extended_set_enable && instr[7:0] <= OFFSET_MAX;
    assign ea = stack_frame_pointer + 12'(instr[7:0]);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // Properties
    property p_phase; phase != 2'd0 |=> phase == 2'($past(phase) + 2'd1); endproperty
    a_phase: assert property (p_phase) else $error("phase skipped");
    property p_fill; go && $past(extended_set_enable) && instr[15:8] == OPC_FILL_ONES
        |-> ##4 done && last_wdata == FILL_VALUE && last_addr == $past(ea, 4); endproperty
    a_fill: assert property (p_fill) else $error("fill wrong");
    property p_bit; go && $past(extended_set_enable) && instr[15:12] == OPC_BIT_SET && !instr[8]
        |-> ##4 done && last_addr == $past(ea, 4) && last_wdata[$past(instr[11:9], 4)]; endproperty
    a_bit: assert property (p_bit) else $error("bit set wrong");
    property p_off; phase == 2'd0 && !extended_set_enable && !$past(extended_set_enable)
        |=> !indexed_hit ##3 !done; endproperty
    a_off: assert property (p_off) else $error("ran while off");
    property p_big; phase == 2'd0 && instr[7:0] > OFFSET_MAX |-> ##4 !done; endproperty
    a_big: assert property (p_big) else $error("large arg ran");
    property p_flag; phase == 2'd0 && instr[15:12] == OPC_BIT_SET && instr[8] |-> ##4 !done; endproperty
    a_flag: assert property (p_flag) else $error("flag set ran");
    property p_done; done |=> !done; endproperty
    a_done: assert property (p_done) else $error("done too long");
    property p_hold; phase != 2'd0 |=> $stable(indexed_hit); endproperty
    a_hold: assert property (p_hold) else $error("hit moved");
    c_fill: cover property (go && instr[15:8] == OPC_FILL_ONES);
    c_bit: cover property (go && instr[15:12] == OPC_BIT_SET);
    c_big: cover property (phase == 2'd0 && instr[7:0] > OFFSET_MAX);
endmodule : iobso_chk

bind iobso_exec iobso_chk iobso_chk_i (.clk(clk), .rst(rst), .extended_set_enable(extended_set_enable),
    .instr(instr), .instr_valid(instr_valid), .stack_frame_pointer(stack_frame_pointer), .phase(phase),
    .indexed_hit(indexed_hit), .done(done), .last_addr(last_addr), .last_wdata(last_wdata));

// ==== tb/tb_indexed_offset_bit_set_ops.sv ====
// Bench for iobso_exec: bit-set and fill-ones indexed forms, and refused words.
// Assumes the data memory array is reachable as u_mem.mem_r for preloading.
`timescale 1ns/100ps
module tb_indexed_offset_bit_set_ops;
    import iobso_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b0;
    logic vld = 1'b0;
    logic [15:0] w = 16'h0000;
    logic [11:0] fp = 12'h000;
    logic [1:0] phase;
    logic hit;
    logic done;
    logic [11:0] la;
    logic [7:0] ld;
    int err_total = 0;
    int compares = 0;
    iobso_exec iobso_exec_i (.clk(clk), .rst(rst), .extended_set_enable(en), .instr(w), .instr_valid(vld),
        .stack_frame_pointer(fp), .phase(phase), .indexed_hit(hit), .done(done), .last_addr(la), .last_wdata(ld));
    // ==========================================================
    // Clock, 50 ns period
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic print_verdict();
        $display("compares=%0d errors=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Enable settles two clocks early since the block registers it before use
    task automatic run(input logic e, input logic [15:0] iw, input logic [11:0] p, input logic ok, input logic [7:0] d);
        int n = 0;
        @(posedge clk) en <= e;
        repeat (2) @(posedge clk);
        do begin
            @(negedge clk);
            n++;
        end while (phase !== 2'd3 && n < 8);
        chk(12'(phase), 12'h003);
        if (phase !== 2'd3) print_verdict();
        @(posedge clk);
        w <= iw;
        fp <= p;
        vld <= 1'b1;
        repeat (4) @(posedge clk);
        vld <= 1'b0;
        @(negedge clk);
        chk(12'(done), 12'(ok));
        chk(12'(hit), 12'(ok));
        if (ok) begin
            chk(la, p + 12'(iw[7:0]));
            chk(12'(ld), 12'(d));
        end
    endtask : run
    task automatic t_bit_set();
        for (int b = 0; b < 8; b++) begin
            iobso_exec_i.u_mem.mem_r[12'hA0A] = 8'h55;
            run(1'b1, {4'h8, 3'(b), 1'b0, 8'h0A}, 12'hA00, 1'b1, 8'h55 | (8'h01 << b));
        end
        $display("bit set test end");
    endtask : t_bit_set
    // Largest offset with a wrapping pointer, then a zero pointer
    task automatic t_fill();
        iobso_exec_i.u_mem.mem_r[12'h04F] = 8'h00;
        run(1'b1, 16'h685F, 12'hFF0, 1'b1, 8'hFF);
        iobso_exec_i.u_mem.mem_r[12'h020] = 8'h11;
        run(1'b1, 16'h8E20, 12'h000, 1'b1, 8'h91);
        $display("fill test end");
    endtask : t_fill
    task automatic t_refuse();
        run(1'b0, 16'h680A, 12'hA00, 1'b0, 8'h00);
        run(1'b1, 16'h6860, 12'hA00, 1'b0, 8'h00);
        run(1'b1, 16'h8E60, 12'hA00, 1'b0, 8'h00);
        run(1'b1, 16'h810A, 12'hA00, 1'b0, 8'h00);
        $display("refuse test end");
    endtask : t_refuse
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_bit_set();
        t_fill();
        t_refuse();
        print_verdict();
    end
endmodule : tb_indexed_offset_bit_set_ops
